// File: pmt_host.sv
`timescale 1ns/1ps
`default_nettype none
module pmt_host
  import pmt_pkg::*;
(
  input wire logic CLK,
  input wire logic NRST,
  input wire logic [2:0] PIO_MODE,
  input wire logic [1:0] DMA_MODE,
  input wire logic [15:0] ID_MIN_CYCLE_NS,
  input wire logic REQ_VALID,
  output logic REQ_READY,
  input wire pmt_req_s REQ,
  output logic RSP_VALID,
  input wire logic RSP_READY,
  output pmt_rsp_s RSP,
  output logic [15:0] DD_O,
  input wire logic [15:0] DD_I,
  output logic DD_OE,
  output logic [2:0] DA,
  output logic [1:0] CS_N,
  output logic DIOR_N,
  output logic DIOW_N,
  output logic DMACK_N,
  input wire logic IORDY,
  input wire logic DMARQ
);

  typedef enum {S_IDLE, S_SETUP, S_ACTIVE, S_WAIT, S_RECOV, S_HOLD} pmt_state_e;

  pmt_state_e state_reg, state_next;
  logic [7:0] cnt_reg, cnt_next;
  logic [7:0] cyc_reg, cyc_next;
  pmt_req_s cur_reg, cur_next;
  logic [2:0] pmode_reg, pmode_next;
  logic [1:0] dmode_reg, dmode_next;
  logic [15:0] dd_o_reg, dd_o_next;
  logic dd_oe_reg, dd_oe_next;
  logic rd_n_reg, rd_n_next, wr_n_reg, wr_n_next, ack_n_reg, ack_n_next;
  logic push_valid;
  pmt_rsp_s push_data;
  logic push_ready;
  pmt_rsp_s buf_reg [2];
  pmt_rsp_s buf_next [2];
  logic [1:0] fill_reg, fill_next;
  logic ready_reg, ready_next;
  logic valid_reg, valid_next;
  logic [1:0] cs_n_reg, cs_n_next;

  // minimum cycle figure: larger of the mode table and the device's reported value
  function automatic logic [7:0] min_cyc(input logic dma, input logic [2:0] pm,
                                         input logic [1:0] dm, input logic [15:0] rep);
    int t;
    t = dma ? DMA_CYCLE_NS[dm] : PIO_CYCLE_NS[pm];
    if (int'(rep) > t) begin
      t = int'(rep);
    end
    return pmt_cyc(t);
  endfunction : min_cyc

  function automatic logic [7:0] act_cyc(input logic dma, input logic [2:0] pm,
                                         input logic [1:0] dm);
    int t;
    t = dma ? DMA_ACTIVE_NS[dm] : PIO_ACTIVE_NS[pm];
    if (!dma && pmt_cyc(READY_SAMPLE_DELAY_NS) > pmt_cyc(t)) begin
      t = READY_SAMPLE_DELAY_NS;
    end
    return pmt_cyc(t);
  endfunction : act_cyc

  function automatic logic [7:0] rec_cyc(input pmt_req_s r, input logic [2:0] pm,
                                         input logic [1:0] dm);
    int t;
    if (r.dma) begin
      t = r.write ? DMA_NEG_WR_NS[dm] : DMA_NEG_RD_NS[dm];
    end else begin
      t = PIO_RECOV_NS[pm];
      if (PIO_HOLD_NS[pm] > t) begin
        t = PIO_HOLD_NS[pm];
      end
    end
    if (!r.write && READ_BUS_RELEASE_TIME_NS > t) begin
      t = READ_BUS_RELEASE_TIME_NS;
    end
    return pmt_cyc(t);
  endfunction : rec_cyc

  assign REQ_READY = ready_reg;

  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_reg + 8'h01;
    cyc_next = cyc_reg + 8'h01;
    cur_next = cur_reg;
    pmode_next = pmode_reg;
    dmode_next = dmode_reg;
    dd_o_next = dd_o_reg;
    dd_oe_next = dd_oe_reg;
    rd_n_next = rd_n_reg;
    wr_n_next = wr_n_reg;
    ack_n_next = ack_n_reg;
    push_valid = 1'b0;
    push_data = '{data: DD_I, write: cur_reg.write};
    case (state_reg)
      S_IDLE: begin
        if (REQ_VALID) begin
          cur_next = REQ;
          // modes above the supported maximum fall back to the defaults
          pmode_next = (PIO_MODE > 3'(PIO_MODE_MAX)) ? PIO_MODE_RESET : PIO_MODE;
          dmode_next = (DMA_MODE > 2'(DMA_MODE_MAX)) ? DMA_MODE_RESET : DMA_MODE;
          dd_o_next = REQ.data;
          dd_oe_next = REQ.write;
          ack_n_next = !REQ.dma;
          cnt_next = CNT_RESET;
          cyc_next = CNT_RESET;
          state_next = S_SETUP;
        end
      end
      S_SETUP: begin
        // address leads a pio strobe by at least setup time; a dma strobe follows ack one clock later, with no setup count
        if (cur_reg.dma || cnt_reg + 8'h01 >= pmt_cyc(PIO_SETUP_NS[pmode_reg])) begin
          rd_n_next = cur_reg.write;
          wr_n_next = !cur_reg.write;
          cnt_next = CNT_RESET;
          state_next = S_ACTIVE;
        end
      end
      S_ACTIVE: begin
        if (cnt_reg + 8'h01 >= act_cyc(cur_reg.dma, pmode_reg, dmode_reg)) begin
          state_next = cur_reg.dma ? S_HOLD : S_WAIT;
        end
      end
      S_WAIT: begin
        // ready is sampled after the ready sample delay; low holds the strobe open
        // only reads need room in the buffer; a write never waits on it
        if (IORDY && (cur_reg.write || push_ready)) begin
          state_next = S_HOLD;
        end
      end
      S_HOLD: begin
        if (cur_reg.write || push_ready) begin
          push_valid = !cur_reg.write;
          rd_n_next = 1'b1;
          wr_n_next = 1'b1;
          cnt_next = CNT_RESET;
          state_next = S_RECOV;
        end
      end
      S_RECOV: begin
        if (cnt_reg == 8'h00) begin
          dd_oe_next = 1'b0;
        end
        // recovery stretched until the whole cycle also meets its minimum
        if (cnt_reg + 8'h01 >= rec_cyc(cur_reg, pmode_reg, dmode_reg) &&
            cnt_reg + 8'h01 >= pmt_cyc(STROBE_TO_ACK_HOLD_NS[dmode_reg]) &&
            cyc_reg + 8'h01 >= min_cyc(cur_reg.dma, pmode_reg, dmode_reg,
                                       ID_MIN_CYCLE_NS)) begin
          // ack stays low across a burst while the device still requests and another dma request is already waiting
          ack_n_next = !(cur_reg.dma && DMARQ && REQ_VALID && REQ.dma);
          state_next = S_IDLE;
        end
      end
      default: state_next = S_IDLE;
    endcase
    // registered so that the handshake and selects leave straight from flops
    ready_next = (state_next == S_IDLE);
    cs_n_next = (state_next == S_IDLE) ? 2'b11 : cur_next.cs_n;
  end

  always_ff @(posedge CLK) begin
    if (!NRST) begin
      state_reg <= S_IDLE;
      cnt_reg <= CNT_RESET;
      cyc_reg <= CNT_RESET;
      cur_reg <= '0;
      pmode_reg <= PIO_MODE_RESET;
      dmode_reg <= DMA_MODE_RESET;
      dd_o_reg <= '0;
      dd_oe_reg <= 1'b0;
      rd_n_reg <= 1'b1;
      wr_n_reg <= 1'b1;
      ack_n_reg <= 1'b1;
      ready_reg <= 1'b1;
      cs_n_reg <= 2'b11;
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      cyc_reg <= cyc_next;
      cur_reg <= cur_next;
      pmode_reg <= pmode_next;
      dmode_reg <= dmode_next;
      dd_o_reg <= dd_o_next;
      dd_oe_reg <= dd_oe_next;
      rd_n_reg <= rd_n_next;
      wr_n_reg <= wr_n_next;
      ack_n_reg <= ack_n_next;
      ready_reg <= ready_next;
      cs_n_reg <= cs_n_next;
    end
  end

  // two-entry read buffer; strobe held asserted while it is full
  assign push_ready = (fill_reg != 2'd2);

  always_comb begin
    buf_next = buf_reg;
    fill_next = fill_reg;
    if (RSP_VALID && RSP_READY) begin
      buf_next[0] = buf_reg[1];
      fill_next = fill_next - 2'd1;
    end
    if (push_valid) begin
      buf_next[fill_next[0]] = push_data;
      fill_next = fill_next + 2'd1;
    end
    valid_next = (fill_next != 2'd0);
  end

  always_ff @(posedge CLK) begin
    if (!NRST) begin
      buf_reg <= '{default: '0};
      fill_reg <= 2'd0;
      valid_reg <= 1'b0;
    end else begin
      buf_reg <= buf_next;
      fill_reg <= fill_next;
      valid_reg <= valid_next;
    end
  end

  assign RSP_VALID = valid_reg;
  assign RSP = buf_reg[0];
  assign DD_O = dd_o_reg;
  assign DD_OE = dd_oe_reg;
  assign DA = cur_reg.addr;
  assign CS_N = cs_n_reg;
  assign DIOR_N = rd_n_reg;
  assign DIOW_N = wr_n_reg;
  assign DMACK_N = ack_n_reg;

endmodule : pmt_host
`default_nettype wire

// File: pmt_pkg.sv
package pmt_pkg;

  localparam int CLK_PERIOD_NS = 50;

  // pio timing per mode 0..4, ns
  localparam int PIO_CYCLE_NS [5] = '{600, 383, 240, 180, 120};
  localparam int PIO_ACTIVE_NS [5] = '{165, 125, 100, 80, 70};
  localparam int PIO_RECOV_NS [5] = '{0, 0, 0, 70, 25};
  localparam int PIO_SETUP_NS [5] = '{70, 50, 30, 30, 25};
  localparam int PIO_HOLD_NS [5] = '{20, 15, 10, 10, 10};
  localparam int READY_SAMPLE_DELAY_NS = 35;
  localparam int READ_BUS_RELEASE_TIME_NS = 30;

  // multiword dma timing per mode 0..2, ns
  localparam int DMA_CYCLE_NS [3] = '{480, 150, 120};
  localparam int DMA_ACTIVE_NS [3] = '{215, 80, 70};
  localparam int DMA_NEG_RD_NS [3] = '{50, 50, 25};
  localparam int DMA_NEG_WR_NS [3] = '{215, 50, 25};
  localparam int STROBE_TO_ACK_HOLD_NS [3] = '{20, 5, 5};
  localparam int READ_TO_REQUEST_DELAY_NS [3] = '{120, 40, 35};

  localparam int PIO_MODE_MAX = 4;
  localparam int DMA_MODE_MAX = 2;

  // identify words holding the reported minimum cycle times
  localparam logic [7:0] ID_WORD_PIO_CYCLE = 8'h44;
  localparam logic [7:0] ID_WORD_DMA_CYCLE = 8'h41;

  localparam logic [2:0] PIO_MODE_RESET = 3'h0;
  localparam logic [1:0] DMA_MODE_RESET = 2'h0;
  localparam logic [7:0] CNT_RESET = 8'h00;

  // least-time ns to cycles, rounded up, never below one
  function automatic logic [7:0] pmt_cyc(input int ns);
    int c;
    c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    if (c < 1) begin
      c = 1;
    end
    return c[7:0];
  endfunction : pmt_cyc

  typedef struct packed {
    logic write;
    logic dma;
    logic [2:0] addr;
    logic [1:0] cs_n;
    logic [15:0] data;
  } pmt_req_s;

  typedef struct packed {
    logic [15:0] data;
    logic write;
  } pmt_rsp_s;

endpackage : pmt_pkg

// File: pmt_host_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module pmt_chk
  import pmt_pkg::*;
(
  input wire logic CLK,
  input wire logic NRST,
  input wire logic [2:0] PIO_MODE,
  input wire logic [1:0] DMA_MODE,
  input wire logic DIOR_N,
  input wire logic DIOW_N,
  input wire logic DMACK_N,
  input wire logic IORDY
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!NRST);
  sequence s_quiet;
    !$fell(DIOR_N) && !$fell(DIOW_N);
  endsequence
  sequence s_pio;
    $fell(DIOR_N) && DMACK_N && PIO_MODE == 3'h0;
  endsequence
  sequence s_dma;
    $fell(DIOR_N) && !DMACK_N && DMA_MODE == 2'h0;
  endsequence
  a_pio_active: assert property (s_pio |-> !DIOR_N [*4])
    else $error("pio strobe short");
  a_pio_cycle: assert property (s_pio |=> s_quiet [*8] ##1 s_quiet [*3])
    else $error("pio cycle short");
  a_ready_wait: assert property ($rose(DIOR_N) && DMACK_N |-> $past(IORDY))
    else $error("pio ended while not ready");
  a_dma_active: assert property (s_dma |-> !DIOR_N [*5])
    else $error("dma strobe short");
  a_dma_cycle: assert property (s_dma |=> s_quiet [*8] ##1 s_quiet)
    else $error("dma cycle short");
  a_ack_hold: assert property ($rose(DMACK_N) |-> $past(DIOR_N) && $past(DIOW_N))
    else $error("ack dropped under strobe");
endmodule : pmt_chk
bind pmt_host pmt_chk chk_u (.CLK(CLK), .NRST(NRST), .PIO_MODE(PIO_MODE), .DMA_MODE(DMA_MODE),
  .DIOR_N(DIOR_N), .DIOW_N(DIOW_N), .DMACK_N(DMACK_N), .IORDY(IORDY));
`default_nettype wire

// File: pmt_dev.sv
`timescale 1ns/1ps
`default_nettype none
module pmt_dev
  import pmt_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic dior_n,
  input wire logic diow_n,
  input wire logic dmack_n,
  input wire logic [15:0] dd_o,
  input wire logic slow,
  output logic [15:0] dd_i,
  output logic iordy,
  output logic dmarq,
  output logic [15:0] id_cycle,
  output logic [15:0] wr_data
);
  logic [15:0] word_reg;
  logic [2:0] wait_reg;
  logic [1:0] left_reg;
  logic rd_d_reg;
  // one figure serves both identify words, no lower than any mode minimum (equal to pio mode 0)
  assign id_cycle = 16'h0258;
  // a released bus shows the inverse, so a stale word cannot pass
  assign dd_i = dior_n ? ~word_reg : word_reg;
  assign iordy = wait_reg == 3'h0;
  assign dmarq = left_reg != 2'h0;
  always_ff @(posedge clk) begin
    rd_d_reg <= dior_n;
    if (!diow_n) wr_data <= dd_o;
    if (!nrst) begin
      word_reg <= 16'ha000;
      wait_reg <= 3'h0;
      left_reg <= 2'h2;
    end else begin
      // strobe lengths are never judged: any stretch is accepted
      if (!dior_n && rd_d_reg && slow) wait_reg <= 3'h7;
      else if (wait_reg != 3'h0) wait_reg <= wait_reg - 3'h1;
      if (dior_n && !rd_d_reg) word_reg <= word_reg + 16'h0001;
      if (dior_n && !rd_d_reg && !dmack_n && dmarq) left_reg <= left_reg - 2'h1;
    end
  end
endmodule : pmt_dev
`default_nettype wire

// File: tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
  import pmt_pkg::*;
  logic clk = 1'b0, nrst = 1'b0, req_valid = 1'b0, rsp_ready = 1'b0, slow = 1'b0;
  logic req_ready, rsp_valid, dd_oe, dior_n, diow_n, dmack_n, iordy, dmarq;
  logic [2:0] pio_mode = 3'h0;
  logic [1:0] dma_mode = 2'h0;
  logic [2:0] da;
  logic [1:0] cs_n;
  logic [15:0] dd_o, dd_i, id_cycle, wr_data;
  pmt_req_s req = '0;
  pmt_rsp_s rsp;
  int bad_count = 0, checks = 0;
  pmt_host dut_u (.CLK(clk), .NRST(nrst), .PIO_MODE(pio_mode), .DMA_MODE(dma_mode),
    .ID_MIN_CYCLE_NS(id_cycle), .REQ_VALID(req_valid), .REQ_READY(req_ready), .REQ(req),
    .RSP_VALID(rsp_valid), .RSP_READY(rsp_ready), .RSP(rsp), .DD_O(dd_o), .DD_I(dd_i),
    .DD_OE(dd_oe), .DA(da), .CS_N(cs_n), .DIOR_N(dior_n), .DIOW_N(diow_n), .DMACK_N(dmack_n),
    .IORDY(iordy), .DMARQ(dmarq));
  pmt_dev dev_u (.clk(clk), .nrst(nrst), .dior_n(dior_n), .diow_n(diow_n), .dmack_n(dmack_n),
    .dd_o(dd_o), .slow(slow), .dd_i(dd_i), .iordy(iordy), .dmarq(dmarq), .id_cycle(id_cycle),
    .wr_data(wr_data));
  initial begin
    forever #25 clk = ~clk;
  end
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : tally_and_finish
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  // sampled at falling edges, where the design's outputs have settled
  task automatic wait_for(input bit on_rsp);
    int n;
    for (n = 0; n < 300 && (on_rsp ? rsp_valid : req_ready) !== 1'b1; n++) @(negedge clk);
    if (n == 300) begin
      bad_count++;
      tally_and_finish();
    end
  endtask : wait_for
  task automatic send(input logic wr, input logic dma);
    @(negedge clk);
    req <= '{write: wr, dma: dma, addr: 3'h5, cs_n: 2'h2, data: 16'h5a3c};
    req_valid <= 1'b1;
    wait_for(1'b0);
    @(negedge clk);
    req_valid <= 1'b0;
  endtask : send
  task automatic pop(input logic [15:0] exp);
    @(negedge clk);
    rsp_ready <= 1'b1;
    wait_for(1'b1);
    chk("read word", rsp.data, exp);
    chk("read flag", {15'h0000, rsp.write}, 16'h0000);
    @(negedge clk);
    rsp_ready <= 1'b0;
  endtask : pop
  task automatic t_write();
    send(1'b1, 1'b0);
    chk("write select", {10'h000, dd_oe, da, cs_n}, 16'h0036);
    wait_for(1'b0);
    chk("written word", wr_data, 16'h5a3c);
    chk("write release", {13'h0000, dd_oe, cs_n}, 16'h0003);
    $display("write test done");
  endtask : t_write
  // device stretches every read while the receiver stalls on a full buffer
  task automatic t_fill();
    slow <= 1'b1;
    for (int i = 0; i < 3; i++) send(1'b0, 1'b0);
    chk("buffer full", {15'h0000, rsp_valid}, 16'h0001);
    for (int i = 0; i < 3; i++) pop(16'ha000 + 16'(i));
    wait_for(1'b0);
    chk("buffer empty", {15'h0000, rsp_valid}, 16'h0000);
    slow <= 1'b0;
    $display("fill test done");
  endtask : t_fill
  task automatic t_dma();
    send(1'b0, 1'b1);
    chk("ack in burst", {15'h0000, dmack_n}, 16'h0000);
    send(1'b0, 1'b1);
    pop(16'ha003);
    pop(16'ha004);
    wait_for(1'b0);
    chk("ack after burst", {15'h0000, dmack_n}, 16'h0001);
    $display("dma test done");
  endtask : t_dma
  // reset cuts a dma read; then an out-of-range pio mode must run at mode 0 timing
  task automatic t_reset();
    int n;
    send(1'b0, 1'b1);
    repeat (3) @(negedge clk);
    nrst <= 1'b0;
    repeat (2) @(negedge clk);
    chk("pins in reset", {12'h000, dior_n, diow_n, dmack_n, dd_oe}, 16'h000e);
    chk("select in reset", {13'h0000, rsp_valid, cs_n}, 16'h0003);
    nrst <= 1'b1;
    pio_mode <= 3'h7;
    send(1'b0, 1'b0);
    for (n = 0; n < 50 && dior_n !== 1'b0; n++) @(negedge clk);
    for (n = 0; n < 50 && dior_n === 1'b0; n++) @(negedge clk);
    if (n == 50) begin
      bad_count++;
      tally_and_finish();
    end
    chk("fallback strobe", {15'h0000, n * CLK_PERIOD_NS >= PIO_ACTIVE_NS[0]}, 16'h0001);
    pop(16'ha000);
    $display("reset test done");
  endtask : t_reset
  initial begin
    repeat (20) @(negedge clk);
    nrst <= 1'b1;
    t_write();
    t_fill();
    t_dma();
    t_reset();
    tally_and_finish();
  end
endmodule : tb
`default_nettype wire
